// *** rtl/ssrdm_pkg.sv ***
// Package for the speed, stop ramp and direction safety monitor.
// Assumes a 50 MHz ref_clk and a millisecond time base derived from it.
package ssrdm_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int SPEED_W = 32;
  localparam int TIME_W = 32;

  localparam logic signed [SPEED_W-1:0] TRIP_NEG_RST = 32'sh0000_0000;
  localparam logic signed [SPEED_W-1:0] TRIP_POS_RST = 32'sh0000_0000;
  localparam logic [TIME_W-1:0] MUTE_MS_RST = 32'h0000_0000;
  localparam logic [TIME_W-1:0] INIT_RANGE_MS_RST = 32'h0000_0000;
  localparam logic [TIME_W-1:0] MIN_RAMP_MS_RST = 32'h0000_0000;
  localparam logic [TIME_W-1:0] MAX_RAMP_MS_RST = 32'h0000_0001;
  localparam logic [TIME_W-1:0] MAX_RAMP_MS_LOW = 32'h0000_0001;
  localparam logic [TIME_W-1:0] DIR_DELAY_MS_RST = 32'h0000_0000;

  typedef enum logic [0:0] {
    SSRDM_DIR_VER_OFF = 1'b0,
    SSRDM_DIR_VER_ONE = 1'b1
  } ssrdm_dir_ver_t;

  typedef enum logic [0:0] {
    SSRDM_ACT_RAMP = 1'b0,
    SSRDM_ACT_TIME = 1'b1
  } ssrdm_act_t;

  typedef enum logic [1:0] {
    SSRDM_ACK_MANUAL = 2'h0,
    SSRDM_ACK_AUTO = 2'h1,
    SSRDM_ACK_BUS = 2'h2,
    SSRDM_ACK_BOTH = 2'h3
  } ssrdm_ack_t;

  typedef struct packed {
    logic [TIME_W-1:0] min_ms;
    logic [TIME_W-1:0] max_ms;
  } ssrdm_ramp_cfg_t;

  typedef struct packed {
    ssrdm_dir_ver_t version;
    logic pos_enable;
    logic neg_enable;
    ssrdm_act_t act_mode;
    logic [TIME_W-1:0] delay_ms;
    ssrdm_ack_t ack_mode;
  } ssrdm_dir_cfg_t;

endpackage

// *** rtl/ssrdm_ms_timer.sv ***
// Millisecond down-free elapsed timer for the safety monitor.
// Assumes ref_clk at the package rate; counts while run is high.
`timescale 1ns/1ns
module ssrdm_ms_timer #(
  parameter int unsigned CYC_MS = ssrdm_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  output logic [ssrdm_pkg::TIME_W-1:0] elapsed_ms
);
  import ssrdm_pkg::*;

  logic [31:0] cyc_reg;
  logic tick;

  assign tick = run && (cyc_reg == 32'(CYC_MS - 1));

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run || tick) begin
      cyc_reg <= 32'h0000_0000;
    end else begin
      cyc_reg <= cyc_reg + 32'h0000_0001;
    end
  end

  // Saturates so that a very long run never wraps back to a small time.
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run) begin
      elapsed_ms <= '0;
    end else if (tick && elapsed_ms != '1) begin
      elapsed_ms <= elapsed_ms + 32'h0000_0001;
    end
  end
endmodule // ssrdm_ms_timer

// *** rtl/ssrdm_ramp_check.sv ***
// One stop ramp supervisor: checks speed against min and max ramps to zero.
// Assumes monitoring start is a one-cycle pulse and speed magnitude is given.
`timescale 1ns/1ns
module ssrdm_ramp_check #(
  parameter int unsigned CYC_MS = ssrdm_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [ssrdm_pkg::SPEED_W-1:0] speed_abs,
  input wire ssrdm_pkg::ssrdm_ramp_cfg_t cfg,
  input wire logic [ssrdm_pkg::TIME_W-1:0] init_range_ms,
  output logic active,
  output logic at_zero,
  output logic fault
);
  import ssrdm_pkg::*;

  logic [SPEED_W-1:0] start_speed_reg;
  logic [TIME_W-1:0] t_ms;
  logic [63:0] max_allow;
  logic [63:0] min_allow;
  logic [TIME_W-1:0] t_max;
  logic [TIME_W-1:0] max_ms_eff;

  ssrdm_ms_timer #(.CYC_MS(CYC_MS)) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(active),
    .elapsed_ms(t_ms)
  );

  assign at_zero = (speed_abs == '0);
  assign max_ms_eff = (cfg.max_ms < MAX_RAMP_MS_LOW) ? MAX_RAMP_MS_LOW : cfg.max_ms;
  // The max ramp is shifted later by the initial range with the same slope.
  assign t_max = (t_ms > init_range_ms) ? t_ms - init_range_ms : '0;

  always_comb begin
    max_allow = 64'(start_speed_reg);
    if (t_max >= max_ms_eff) begin
      max_allow = 64'h0000_0000_0000_0000;
    end else begin
      max_allow = (64'(start_speed_reg) * 64'(max_ms_eff - t_max)) / 64'(max_ms_eff);
    end
    min_allow = 64'h0000_0000_0000_0000;
    if (cfg.min_ms != '0 && t_ms < cfg.min_ms) begin
      min_allow = (64'(start_speed_reg) * 64'(cfg.min_ms - t_ms)) / 64'(cfg.min_ms);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      active <= 1'b0;
      start_speed_reg <= '0;
    end else if (start) begin
      active <= 1'b1;
      start_speed_reg <= speed_abs;
    end else if (abort || at_zero) begin
      active <= 1'b0;
    end
  end

  // A zero minimum time leaves the lower ramp unmonitored.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fault <= 1'b0;
    end else if (active && 64'(speed_abs) > max_allow) begin
      fault <= 1'b1;
    end else if (active && cfg.min_ms != '0 && 64'(speed_abs) < min_allow) begin
      fault <= 1'b1;
    end else if (start) begin
      fault <= 1'b0;
    end
  end
endmodule // ssrdm_ramp_check

// *** rtl/ssrdm_top.sv ***
// Speed window guard, two stop ramp profiles and the direction guard.
// Assumes all inputs synchronous to ref_clk; configuration is held static.
`timescale 1ns/1ns
module ssrdm_top #(
  parameter int unsigned CYC_MS = ssrdm_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic signed [ssrdm_pkg::SPEED_W-1:0] speed,
  input wire logic speed_is_estimate,
  input wire logic signed [ssrdm_pkg::SPEED_W-1:0] trip_limit_neg,
  input wire logic signed [ssrdm_pkg::SPEED_W-1:0] trip_limit_pos,
  input wire logic [ssrdm_pkg::TIME_W-1:0] window_mute_ms,
  input wire logic [ssrdm_pkg::TIME_W-1:0] init_range_ms,
  input wire ssrdm_pkg::ssrdm_ramp_cfg_t profile_zero_cfg,
  input wire ssrdm_pkg::ssrdm_ramp_cfg_t profile_one_cfg,
  input wire logic stop_zero_start,
  input wire logic stop_one_start,
  input wire ssrdm_pkg::ssrdm_dir_cfg_t dir_cfg,
  input wire logic dir_pos_request,
  input wire logic dir_neg_request,
  input wire logic ack_input,
  input wire logic ack_fieldbus,
  output logic window_trip,
  output logic ramp_zero_fault,
  output logic ramp_one_fault,
  output logic ramp_zero_active,
  output logic ramp_one_active,
  output logic dir_pos_active,
  output logic dir_neg_active,
  output logic dir_trip,
  output logic dir_ack_pending
);
  import ssrdm_pkg::*;

  typedef enum logic [4:0] {
    SSRDM_DG_IDLE = 5'b00001,
    SSRDM_DG_RAMP = 5'b00010,
    SSRDM_DG_DELAY = 5'b00100,
    SSRDM_DG_WATCH = 5'b01000,
    SSRDM_DG_ACK = 5'b10000
  } ssrdm_dg_state_t;

  logic [SPEED_W-1:0] speed_abs;
  logic over_pos;
  logic under_neg;
  logic violation;
  logic [TIME_W-1:0] mute_ms;
  logic mute_run;
  logic mute_done;
  logic [TIME_W-1:0] mute_elapsed;
  logic guard_on;
  logic pos_on;
  logic neg_on;
  logic req_any;
  logic req_reg;
  logic req_rise;
  logic ramp_one_start;
  logic r0_at_zero;
  logic r1_at_zero;
  logic [TIME_W-1:0] delay_elapsed;
  logic delay_run;
  logic wrong_dir;
  logic correct_dir;
  logic ack_ok;
  logic dir_pos_sel_reg;
  ssrdm_dg_state_t dg_state_reg;
  ssrdm_dg_state_t dg_state_next;

  assign speed_abs = speed[SPEED_W-1] ? SPEED_W'(-speed) : SPEED_W'(speed);

  // Speed window guard.
  assign under_neg = speed < trip_limit_neg;
  assign over_pos = speed > trip_limit_pos;
  assign violation = under_neg || over_pos;
  // A measured speed is trusted at once; only the estimate is filtered.
  assign mute_ms = speed_is_estimate ? window_mute_ms : '0;
  assign mute_run = violation && !window_trip;
  assign mute_done = mute_elapsed >= mute_ms;

  ssrdm_ms_timer #(.CYC_MS(CYC_MS)) u_mute_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(mute_run),
    .elapsed_ms(mute_elapsed)
  );

  // The trip latches; clearing it takes a reset of the monitor.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      window_trip <= 1'b0;
    end else if (violation && mute_done) begin
      window_trip <= 1'b1;
    end
  end

  // Stop ramp profiles.
  ssrdm_ramp_check #(.CYC_MS(CYC_MS)) u_ramp_zero (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(stop_zero_start),
    .abort(1'b0),
    .speed_abs(speed_abs),
    .cfg(profile_zero_cfg),
    .init_range_ms(init_range_ms),
    .active(ramp_zero_active),
    .at_zero(r0_at_zero),
    .fault(ramp_zero_fault)
  );

  assign ramp_one_start = stop_one_start
    || (req_rise && dg_state_reg == SSRDM_DG_IDLE && dir_cfg.act_mode == SSRDM_ACT_RAMP);

  ssrdm_ramp_check #(.CYC_MS(CYC_MS)) u_ramp_one (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(ramp_one_start),
    .abort(1'b0),
    .speed_abs(speed_abs),
    .cfg(profile_one_cfg),
    .init_range_ms(init_range_ms),
    .active(ramp_one_active),
    .at_zero(r1_at_zero),
    .fault(ramp_one_fault)
  );

  // Direction guard.
  assign guard_on = dir_cfg.version == SSRDM_DIR_VER_ONE;
  assign pos_on = guard_on && dir_cfg.pos_enable && dir_pos_request;
  assign neg_on = guard_on && dir_cfg.neg_enable && dir_neg_request;
  assign req_any = pos_on || neg_on;
  assign req_rise = req_any && !req_reg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      req_reg <= 1'b0;
      dir_pos_sel_reg <= 1'b0;
    end else begin
      req_reg <= req_any;
      if (req_rise) begin
        dir_pos_sel_reg <= pos_on;
      end
    end
  end

  // A positive guard forbids negative speed, and the other way round.
  assign wrong_dir = dir_pos_sel_reg ? speed[SPEED_W-1] : (speed > 0);
  assign correct_dir = !wrong_dir;
  assign delay_run = dg_state_reg == SSRDM_DG_DELAY;

  ssrdm_ms_timer #(.CYC_MS(CYC_MS)) u_delay_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(delay_run),
    .elapsed_ms(delay_elapsed)
  );

  always_comb begin
    ack_ok = 1'b0;
    case (dir_cfg.ack_mode)
      SSRDM_ACK_MANUAL: ack_ok = correct_dir && ack_input;
      SSRDM_ACK_AUTO: ack_ok = !req_any && correct_dir;
      SSRDM_ACK_BUS: ack_ok = !req_any && correct_dir && ack_fieldbus;
      SSRDM_ACK_BOTH: ack_ok = !req_any && correct_dir && (ack_input || ack_fieldbus);
      default: ack_ok = 1'b0;
    endcase
  end

  always_comb begin
    dg_state_next = dg_state_reg;
    case (dg_state_reg)
      SSRDM_DG_IDLE: begin
        if (req_rise) begin
          dg_state_next = (dir_cfg.act_mode == SSRDM_ACT_TIME) ? SSRDM_DG_DELAY : SSRDM_DG_RAMP;
        end
      end
      SSRDM_DG_RAMP: begin
        if (!guard_on) begin
          dg_state_next = SSRDM_DG_IDLE;
        end else if (!ramp_one_active) begin
          dg_state_next = SSRDM_DG_WATCH;
        end
      end
      SSRDM_DG_DELAY: begin
        if (!guard_on) begin
          dg_state_next = SSRDM_DG_IDLE;
        end else if (delay_elapsed >= dir_cfg.delay_ms) begin
          dg_state_next = SSRDM_DG_WATCH;
        end
      end
      SSRDM_DG_WATCH: begin
        if (!guard_on || dir_trip) begin
          dg_state_next = guard_on ? SSRDM_DG_ACK : SSRDM_DG_IDLE;
        end else if (!req_any) begin
          dg_state_next = SSRDM_DG_ACK;
        end
      end
      SSRDM_DG_ACK: begin
        if (ack_ok || !guard_on) begin
          dg_state_next = SSRDM_DG_IDLE;
        end
      end
      default: dg_state_next = SSRDM_DG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dg_state_reg <= SSRDM_DG_IDLE;
    end else begin
      dg_state_reg <= dg_state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !guard_on) begin
      dir_trip <= 1'b0;
    end else if (dg_state_reg == SSRDM_DG_WATCH && wrong_dir) begin
      dir_trip <= 1'b1;
    end else if (dg_state_reg == SSRDM_DG_ACK && ack_ok) begin
      dir_trip <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dir_pos_active <= 1'b0;
      dir_neg_active <= 1'b0;
      dir_ack_pending <= 1'b0;
    end else begin
      dir_pos_active <= dg_state_next == SSRDM_DG_WATCH && dir_pos_sel_reg;
      dir_neg_active <= dg_state_next == SSRDM_DG_WATCH && !dir_pos_sel_reg;
      dir_ack_pending <= dg_state_next == SSRDM_DG_ACK;
    end
  end

  AST_NEG_TRIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (under_neg && !speed_is_estimate) |=> window_trip) else $error("negative trip missed");
  AST_POS_TRIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (over_pos && !speed_is_estimate) |=> window_trip) else $error("positive trip missed");
  AST_NO_FALSE_TRIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!window_trip && !violation) |=> !window_trip) else $error("trip without cause");
  AST_MUTE_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!window_trip && violation && !mute_done) |=> !window_trip) else $error("trip in mute");
  AST_VER_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!guard_on) |=> !dir_trip) else $error("guard acted while off");
  AST_POS_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!dir_cfg.pos_enable && dir_pos_request && !dir_neg_request && dg_state_reg == SSRDM_DG_IDLE)
    |=> dg_state_reg == SSRDM_DG_IDLE) else $error("positive guard acted disabled");
  AST_NEG_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!dir_cfg.neg_enable && dir_neg_request && !dir_pos_request && dg_state_reg == SSRDM_DG_IDLE)
    |=> dg_state_reg == SSRDM_DG_IDLE) else $error("negative guard acted disabled");
  AST_RAMP_MODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req_rise && dg_state_reg == SSRDM_DG_IDLE && dir_cfg.act_mode == SSRDM_ACT_RAMP)
    |=> ramp_one_active) else $error("profile one not started");
  AST_TIME_DELAY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_DELAY && delay_elapsed < dir_cfg.delay_ms)
    |=> dg_state_reg != SSRDM_DG_WATCH) else $error("delay cut short");
  AST_ACK_DIR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && guard_on && wrong_dir) |=> dg_state_reg == SSRDM_DG_ACK)
    else $error("ack accepted in wrong direction");
  AST_ACK_WITHDRAW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && req_any && guard_on && dir_cfg.ack_mode != SSRDM_ACK_MANUAL)
    |=> dg_state_reg == SSRDM_DG_ACK) else $error("ack before withdrawal");
  AST_BUS_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && guard_on && dir_cfg.ack_mode == SSRDM_ACK_BUS && !ack_fieldbus)
    |=> dg_state_reg == SSRDM_DG_ACK) else $error("bus ack without bus");
  AST_BOTH_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && guard_on && dir_cfg.ack_mode == SSRDM_ACK_BOTH
     && !ack_fieldbus && !ack_input) |=> dg_state_reg == SSRDM_DG_ACK)
    else $error("combined ack without source");
  AST_MUTE_TRIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (violation && mute_done && !window_trip)
    |=> window_trip)
    else $error("persistent violation not tripped");
  AST_TRIP_LATCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (window_trip)
    |=> window_trip)
    else $error("window trip released");
  AST_ZERO_START: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (stop_zero_start)
    |=> ramp_zero_active)
    else $error("profile zero not started");
  AST_ONE_START: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ramp_one_start)
    |=> ramp_one_active)
    else $error("profile one start missed");
  // A fault may only be raised while its ramp is being monitored.
  AST_ZERO_QUIET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ramp_zero_active && !ramp_zero_fault)
    |=> !ramp_zero_fault)
    else $error("profile zero fault while idle");
  AST_ONE_QUIET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ramp_one_active && !ramp_one_fault)
    |=> !ramp_one_fault)
    else $error("profile one fault while idle");
  AST_GUARD_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!guard_on)
    |=> !dir_pos_active && !dir_neg_active && !dir_ack_pending)
    else $error("direction guard busy while off");
  AST_DELAY_END: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_DELAY && guard_on && delay_elapsed >= dir_cfg.delay_ms)
    |=> dg_state_reg == SSRDM_DG_WATCH)
    else $error("watch not started after delay");
  AST_RAMP_END: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_RAMP && guard_on && !ramp_one_active)
    |=> dg_state_reg == SSRDM_DG_WATCH)
    else $error("watch not started after ramp");
  AST_TIME_NO_RAMP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req_rise && dg_state_reg == SSRDM_DG_IDLE && dir_cfg.act_mode == SSRDM_ACT_TIME)
    |=> dg_state_reg == SSRDM_DG_DELAY)
    else $error("time mode did not enter delay");
  AST_WRONG_DIR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_WATCH && guard_on && wrong_dir)
    |=> dir_trip)
    else $error("wrong direction not tripped");
  AST_AUTO_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && dir_cfg.ack_mode == SSRDM_ACK_AUTO && !req_any && correct_dir)
    |=> dg_state_reg == SSRDM_DG_IDLE && !dir_trip)
    else $error("automatic ack not generated");
  AST_MANUAL_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && dir_cfg.ack_mode == SSRDM_ACK_MANUAL && ack_input && correct_dir)
    |=> dg_state_reg == SSRDM_DG_IDLE && !dir_trip)
    else $error("manual ack not taken");
  AST_BUS_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dg_state_reg == SSRDM_DG_ACK && dir_cfg.ack_mode == SSRDM_ACK_BUS && !req_any
     && correct_dir && ack_fieldbus)
    |=> dg_state_reg == SSRDM_DG_IDLE)
    else $error("bus ack not taken");
endmodule // ssrdm_top

// *** bench/ssrdm_drive_model.sv ***
// Drive control model that supplies measured speed to the safety monitor.
// Assumes the bench drives load, load_speed and decel_step at the falling edge.
`timescale 1ns/1ns
module ssrdm_drive_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic signed [ssrdm_pkg::SPEED_W-1:0] load_speed,
  input wire logic [ssrdm_pkg::SPEED_W-1:0] decel_step,
  output logic signed [ssrdm_pkg::SPEED_W-1:0] speed
);
  import ssrdm_pkg::*;
  logic signed [SPEED_W-1:0] step_s;
  assign step_s = signed'(decel_step);
  // The drive owns the deceleration ramp; a step past zero is clamped so speed settles at zero.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      speed <= '0;
    end else if (load) begin
      speed <= load_speed;
    end else if (speed > step_s) begin
      speed <= speed - step_s;
    end else if (speed < -step_s) begin
      speed <= speed + step_s;
    end else begin
      speed <= '0;
    end
  end
endmodule // ssrdm_drive_model

// *** bench/ssrdm_top_tb.sv ***
// Self-checking bench for the speed window, stop ramp and direction monitor.
// Assumes a 20 ns clock and a shortened millisecond of five cycles.
`timescale 1ns/1ns
module ssrdm_top_tb;
  import ssrdm_pkg::*;
  localparam int unsigned CMS = 5;
  localparam int LIMIT = 20000;
  typedef struct {
    logic signed [SPEED_W-1:0] spd;
    logic signed [SPEED_W-1:0] neg;
    logic signed [SPEED_W-1:0] pos;
    logic est;
    logic [TIME_W-1:0] mute;
    logic early;
    logic late;
  } ssrdm_win_row_t;
  localparam logic signed [SPEED_W-1:0] L = 32'sh0000_00C8;
  localparam logic signed [SPEED_W-1:0] W = 32'sh0000_03E8;
  localparam logic signed [SPEED_W-1:0] S = 32'sh0000_0032;
  ssrdm_win_row_t rows [9] = '{
    '{32'sh0000_0000, 32'sh0000_0000, 32'sh0000_0000, 1'b0, 32'h0000_0000, 1'b0, 1'b0},
    '{32'sh0000_0001, 32'sh0000_0000, 32'sh0000_0000, 1'b0, 32'h0000_0000, 1'b1, 1'b1},
    '{-32'sh0000_0001, 32'sh0000_0000, 32'sh0000_0000, 1'b0, 32'h0000_0000, 1'b1, 1'b1},
    '{L, -L, L, 1'b0, 32'h0000_0000, 1'b0, 1'b0},
    '{-L, -L, L, 1'b0, 32'h0000_0000, 1'b0, 1'b0},
    '{L + 1, -L, L, 1'b0, 32'h0000_0000, 1'b1, 1'b1},
    '{-L - 1, -L, L, 1'b0, 32'h0000_0000, 1'b1, 1'b1},
    '{L + 1, -L, L, 1'b1, 32'h0000_0002, 1'b0, 1'b1},
    '{L + 1, -L, L, 1'b0, 32'h0000_0002, 1'b1, 1'b1}};
  // Bits: version, pos enable, neg enable, positive request, expected active, expected trip.
  localparam logic [5:0] DROWS [6] = '{6'h1C, 6'h2C, 6'h37, 6'h30, 6'h2B, 6'h18};
  // Pending after bus ack before withdrawal, after withdrawal, after input ack; per ack mode.
  localparam logic [2:0] APEND [4] = '{3'h6, 3'h4, 3'h7, 3'h6};
  logic ref_clk, reset_n, est, load, z_start, o_start, req_pos, req_neg, ack_in, ack_bus;
  logic signed [SPEED_W-1:0] speed, lim_neg, lim_pos, load_speed;
  logic [SPEED_W-1:0] decel_step;
  logic [TIME_W-1:0] mute_ms, init_ms;
  ssrdm_ramp_cfg_t p0_cfg, p1_cfg;
  ssrdm_dir_cfg_t dcfg;
  logic window_trip, r0_fault, r1_fault, r0_act, r1_act, pos_act, neg_act, dir_trip, ack_pend;
  int fails, num_checks, cyc;

  ssrdm_drive_model u_drive (.ref_clk(ref_clk), .reset_n(reset_n), .load(load),
    .load_speed(load_speed), .decel_step(decel_step), .speed(speed));
  ssrdm_top #(.CYC_MS(CMS)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .speed(speed),
    .speed_is_estimate(est), .trip_limit_neg(lim_neg), .trip_limit_pos(lim_pos),
    .window_mute_ms(mute_ms), .init_range_ms(init_ms), .profile_zero_cfg(p0_cfg),
    .profile_one_cfg(p1_cfg), .stop_zero_start(z_start), .stop_one_start(o_start),
    .dir_cfg(dcfg), .dir_pos_request(req_pos), .dir_neg_request(req_neg), .ack_input(ack_in),
    .ack_fieldbus(ack_bus), .window_trip(window_trip), .ramp_zero_fault(r0_fault),
    .ramp_one_fault(r1_fault), .ramp_zero_active(r0_act), .ramp_one_active(r1_act),
    .dir_pos_active(pos_act), .dir_neg_active(neg_act), .dir_trip(dir_trip),
    .dir_ack_pending(ack_pend));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hung handshake would otherwise run forever, so a cycle ceiling cuts it short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic do_reset(input logic signed [SPEED_W-1:0] spd);
    reset_n = 1'b0;
    load = 1'b1;
    load_speed = spd;
    decel_step = '0;
    {z_start, o_start, req_pos, req_neg, ack_in, ack_bus} = '0;
    cycles(4);
    reset_n = 1'b1;
  endtask

  task automatic dir_setup(input logic [2:0] vpn, input ssrdm_act_t act,
                           input logic [TIME_W-1:0] dly, input ssrdm_ack_t ack);
    dcfg = '{version: ssrdm_dir_ver_t'(vpn[2]), pos_enable: vpn[1], neg_enable: vpn[0],
             act_mode: act, delay_ms: dly, ack_mode: ack};
    do_reset(S);
  endtask

  task automatic pulse_ack(input logic bus);
    if (bus) begin
      ack_bus = 1'b1;
    end else begin
      ack_in = 1'b1;
    end
    cycles(3);
    {ack_bus, ack_in} = 2'h0;
    cycles(2);
  endtask

  initial begin
    {est, fails, num_checks, cyc} = '0;
    {lim_neg, lim_pos, mute_ms, init_ms} = '0;
    p0_cfg = '{min_ms: MIN_RAMP_MS_RST, max_ms: MAX_RAMP_MS_RST};
    p1_cfg = p0_cfg;
    dcfg = '{version: SSRDM_DIR_VER_OFF, pos_enable: 1'b0, neg_enable: 1'b0,
             act_mode: SSRDM_ACT_RAMP, delay_ms: '0, ack_mode: SSRDM_ACK_MANUAL};
    do_reset('0);
    chk("outputs after reset", 32'h0000_0000,
        {window_trip, r0_fault, r1_fault, r0_act, r1_act, pos_act, neg_act, dir_trip, ack_pend});
    foreach (rows[i]) begin
      {lim_neg, lim_pos, est, mute_ms} = {rows[i].neg, rows[i].pos, rows[i].est, rows[i].mute};
      do_reset('0);
      load_speed = rows[i].spd;
      cycles(3);
      chk("window_trip early", rows[i].early, window_trip);
      cycles(20);
      chk("window_trip late", rows[i].late, window_trip);
    end
    {lim_neg, lim_pos, est, mute_ms} = {-W, W, 1'b0, 32'h0000_0000};
    foreach (DROWS[i]) begin
      dir_setup(DROWS[i][5:3], SSRDM_ACT_TIME, '0, SSRDM_ACK_MANUAL);
      load_speed = DROWS[i][2] ? S : -S;
      cycles(2);
      {req_pos, req_neg} = {DROWS[i][2], !DROWS[i][2]};
      cycles(4);
      chk("dir active", DROWS[i][1], DROWS[i][2] ? pos_act : neg_act);
      load_speed = -load_speed;
      cycles(4);
      chk("dir_trip", DROWS[i][0], dir_trip);
    end
    for (int m = 0; m < 4; m++) begin
      dir_setup(3'h6, SSRDM_ACT_TIME, '0, ssrdm_ack_t'(m));
      req_pos = 1'b1;
      cycles(4);
      load_speed = -S;
      cycles(4);
      chk("dir_trip on wrong direction", 1'b1, dir_trip);
      pulse_ack(1'b0);
      chk("pending while direction wrong", 1'b1, ack_pend);
      load_speed = '0;
      cycles(3);
      pulse_ack(1'b1);
      chk("pending before withdrawal", APEND[m][2], ack_pend);
      req_pos = 1'b0;
      cycles(4);
      chk("pending after withdrawal", APEND[m][1], ack_pend);
      pulse_ack(1'b0);
      chk("pending after input ack", APEND[m][0], ack_pend);
      pulse_ack(1'b1);
      chk("trip after bus ack", 2'h0, {dir_trip, ack_pend});
    end
    dir_setup(3'h6, SSRDM_ACT_TIME, 32'h0000_0002, SSRDM_ACK_MANUAL);
    req_pos = 1'b1;
    cycles(6);
    chk("active during delay", 1'b0, pos_act);
    cycles(10);
    chk("active after delay", 1'b1, pos_act);
    p1_cfg = '{min_ms: 32'h0000_0000, max_ms: 32'h0000_0004};
    dir_setup(3'h6, SSRDM_ACT_RAMP, '0, SSRDM_ACK_MANUAL);
    load_speed = S + S;
    cycles(2);
    {req_pos, load, decel_step} = {1'b1, 1'b0, 32'h0000_000A};
    cycles(3);
    chk("active while ramping", 1'b0, pos_act);
    cycles(25);
    chk("active after ramp", 2'h2, {pos_act, r1_fault});
    dcfg.version = SSRDM_DIR_VER_OFF;
    for (int i = 0; i < 8; i++) begin
      logic [TIME_W-1:0] mn, mx;
      mn = (i[1:0] == 2'h3) ? 32'h0000_0004 : 32'h0000_0000;
      mx = (i[1:0] == 2'h0) ? 32'h0000_0004 : (i[1:0] == 2'h3) ? 32'h0000_0008 : 32'h0000_0001;
      p0_cfg = '{min_ms: mn, max_ms: mx};
      p1_cfg = p0_cfg;
      init_ms = (i[1:0] == 2'h2) ? 32'h0000_0004 : 32'h0000_0000;
      do_reset(S + S);
      cycles(2);
      {z_start, o_start} = {!i[2], i[2]};
      cycles(1);
      {z_start, o_start, load} = 3'h0;
      decel_step = (i[1:0] == 2'h0) ? 32'h0000_000A : (i[1:0] == 2'h3) ? W : 32'h0000_0000;
      cycles(1);
      chk("ramp active", 1'b1, i[2] ? r1_act : r0_act);
      cycles(12);
      chk("ramp fault", i[1:0] == 2'h1 || i[1:0] == 2'h3, i[2] ? r1_fault : r0_fault);
      cycles(25);
      chk("ramp fault late", i[1:0] != 2'h0, i[2] ? r1_fault : r0_fault);
    end
    end_sim();
  end
endmodule // ssrdm_top_tb
